/* common/fdp_pkg.sv */
// Purpose: Shared constants for the floppy drive port logic
// Assumes: Core clock of 25 MHz (40 ns period)
// Notes:   Register offsets are byte addresses on a 32-bit Avalon-MM slave
package fdp_pkg;
	localparam int unsigned CORE_NS = 40;

	// Least time in ns to whole core cycles, never below one
	function automatic int unsigned fdp_ceil_cyc(input int unsigned ns);
		int unsigned c;
		c = (ns + CORE_NS - 1) / CORE_NS;
		return (c == 0) ? 1 : c;
	endfunction : fdp_ceil_cyc

	// Register map
	localparam int unsigned AVS_AW  = 5;
	localparam logic [4:0]  OFS_OPS  = 5'h00;
	localparam logic [4:0]  OFS_CTRL = 5'h04;
	localparam logic [4:0]  OFS_MODE = 5'h08;
	localparam logic [4:0]  OFS_CMD  = 5'h0C;
	localparam logic [4:0]  OFS_FLUX = 5'h10;
	localparam logic [4:0]  OFS_STAT = 5'h14;

	// Reset values
	localparam logic [7:0]  OPS_RST  = 8'h00;
	localparam logic [1:0]  CTRL_RST = 2'h0;
	localparam logic [1:0]  MODE_RST = 2'h0;

	// Operating modes
	localparam logic [1:0]  MODE_BASE    = 2'h0;
	localparam logic [1:0]  MODE_SPECIAL = 2'h1;
	localparam logic [1:0]  MODE_COMPAT  = 2'h2;

	// Operations register fields
	localparam int unsigned OPS_DS1 = 0;
	localparam int unsigned OPS_DS2 = 1;
	localparam int unsigned OPS_MO1 = 4;
	localparam int unsigned OPS_MO2 = 5;

	// Command register fields
	localparam int unsigned CMD_UNIT  = 0;
	localparam int unsigned CMD_SIDE  = 2;
	localparam int unsigned CMD_WRITE = 3;
	localparam int unsigned CMD_STEP  = 4;
	localparam int unsigned CMD_OUT   = 5;
	localparam int unsigned CMD_INNER = 6;
	localparam int unsigned CMD_CNT   = 8;

	// Status register fields and the control register media change bit
	localparam int unsigned ST_STEP  = 0;
	localparam int unsigned ST_WGATE = 1;
	localparam int unsigned ST_ALT   = 2;
	localparam int unsigned ST_FLUX  = 3;
	localparam int unsigned ST_RDCNT = 8;
	localparam int unsigned CTRL_SWAP = 7;

	// Data rate codes in the control register
	localparam logic [1:0]  RATE_500 = 2'h0;
	localparam logic [1:0]  RATE_300 = 2'h1;
	localparam logic [1:0]  RATE_250 = 2'h2;
	localparam logic [1:0]  RATE_125 = 2'h3;

	// Bit cell times on the main clock
	localparam int unsigned CELL_500_NS  = 2000;
	localparam int unsigned CELL_250_NS  = 4000;
	localparam int unsigned CELL_125_NS  = 8000;
	localparam int unsigned CELL_500_CYC = CELL_500_NS / CORE_NS;
	localparam int unsigned CELL_250_CYC = CELL_250_NS / CORE_NS;
	localparam int unsigned CELL_125_CYC = CELL_125_NS / CORE_NS;
	// Alternate clock edges per 300 kb/s cell (9.6 MHz / 300 kHz)
	localparam int unsigned ALT_EDGES    = 32;

	// Precompensation and pulse timing
	localparam int unsigned PC_SHORT_NS   = 125;
	localparam int unsigned PC_LONG_NS    = 187;
	localparam int unsigned PC_SHORT_CYC  = fdp_ceil_cyc(PC_SHORT_NS);
	localparam int unsigned PC_LONG_CYC   = fdp_ceil_cyc(PC_LONG_NS);
	localparam int unsigned WD_PULSE_NS   = 250;
	localparam int unsigned WD_PULSE_CYC  = fdp_ceil_cyc(WD_PULSE_NS);
	localparam int unsigned WG_LEAD_NS    = 1000;
	localparam int unsigned WG_LEAD_CYC   = fdp_ceil_cyc(WG_LEAD_NS);
	localparam int unsigned STEP_PULSE_NS = 4000;
	localparam int unsigned STEP_PULSE_CYC = fdp_ceil_cyc(STEP_PULSE_NS);
	localparam int unsigned STEP_GAP_NS   = 3000000;
	localparam int unsigned STEP_GAP_CYC  = fdp_ceil_cyc(STEP_GAP_NS);
endpackage : fdp_pkg

/* common/fdp_step_if.sv */
// Purpose: Carrier between the sequencer and the step pulse generator
// Assumes: Both ends run on the core clock
// Notes:   start is a one-cycle pulse taken only while busy is low
interface fdp_step_if;
	logic       start;
	logic [7:0] count;
	logic       busy;
	logic       step_n;
	modport ctl (output start, output count, input busy, input step_n);
	modport gen (input start, input count, output busy, output step_n);
endinterface : fdp_step_if

/* logic/fdp_step_gen.sv */
// Purpose: Emits one low step pulse per track of a multi-track move
// Assumes: Count of zero moves nothing
// Notes:   Gap follows each pulse so the stepper settles before the next
module fdp_step_gen #(
	parameter int unsigned PULSE_CYC = fdp_pkg::STEP_PULSE_CYC,
	parameter int unsigned GAP_CYC   = fdp_pkg::STEP_GAP_CYC
) (
	input  wire logic   i_core_clk,
	input  wire logic   i_rst,
	fdp_step_if.gen     step
);
	import fdp_pkg::*;

	typedef enum logic [1:0] {SG_IDLE, SG_LOW, SG_GAP} fdp_sg_e;

	fdp_sg_e     st_r,  st_nxt;
	logic [7:0]  left_r, left_nxt;
	logic [19:0] tim_r, tim_nxt;

	initial begin
		if (PULSE_CYC < 1 || GAP_CYC < 1 || GAP_CYC > 20'hF_FFFF || PULSE_CYC > 20'hF_FFFF) begin
			$error("fdp_step_gen: timing out of range");
		end
	end

	// Next state of the pulse train
	always_comb begin
		st_nxt   = st_r;
		left_nxt = left_r;
		tim_nxt  = tim_r;
		unique case (st_r)
			SG_IDLE: begin
				if (step.start && step.count != 8'h00) begin
					st_nxt   = SG_LOW;
					left_nxt = step.count;
					tim_nxt  = 20'(PULSE_CYC - 1);
				end
			end
			SG_LOW: begin
				if (tim_r == 20'h0_0000) begin
					st_nxt   = SG_GAP;
					left_nxt = left_r - 8'h01;
					tim_nxt  = 20'(GAP_CYC - 1);
				end else begin
					tim_nxt = tim_r - 20'h0_0001;
				end
			end
			SG_GAP: begin
				if (tim_r != 20'h0_0000) begin
					tim_nxt = tim_r - 20'h0_0001;
				end else if (left_r == 8'h00) begin
					st_nxt = SG_IDLE;
				end else begin
					st_nxt  = SG_LOW;
					tim_nxt = 20'(PULSE_CYC - 1);
				end
			end
		endcase
	end

	// State registers
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			st_r   <= SG_IDLE;
			left_r <= 8'h00;
			tim_r  <= 20'h0_0000;
		end else begin
			st_r   <= st_nxt;
			left_r <= left_nxt;
			tim_r  <= tim_nxt;
		end
	end

	// One low pulse per track [RULE_15]
	assign step.step_n = (st_r != SG_LOW);
	assign step.busy   = (st_r != SG_IDLE);

	AST_STEP_ONE_PER_TRACK: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_15]
		(st_r == SG_LOW && tim_r == 20'h0_0000) |=> step.step_n && left_r == $past(left_r) - 8'h01)
		else $error("step count not tracked per pulse");
endmodule : fdp_step_gen

/* logic/fdp_drive_port.sv */
// Purpose: Drive-side port logic with host registers on Avalon-MM
// Assumes: Drive pins are asynchronous and pass two flip-flops first
// Notes:   Reads answer one cycle after request; writes answer at once
//          unless a flux byte waits for the shifter

// Notes on behaviour
// RULE_01: With change gate low, control read puts media change status on bit 7.
// RULE_02: Operations select with write strobe latches the full data byte.
// RULE_03: Control select with write strobe latches only the two low bits.
// RULE_04: Reset idles the sequencer and returns every output to reset state.
// RULE_05: After reset the mode is base, neither special nor host compatible.
// RULE_06: Each falling edge of the raw read stream counts as one flux transition.
// RULE_07: The alternate clock is used only when the rate field selects it.
// RULE_08: A two-speed spindle drive never gets the alternate clock.
// RULE_09: Standard rate timing comes from the main clock alone.
// RULE_10: Inner-track precompensation is 125 ns when select is high, else 187 ns.
// RULE_11: Side select is high for side 0 and low for side 1.
// RULE_12: Write gate goes low just before writing and stays low meanwhile.
// RULE_13: Write data is a pulse stream, one falling edge per flux transition.
// RULE_14: Step direction is high for outward, low for inward motion.
// RULE_15: One low step pulse is issued per single-track head move.
// RULE_16: Base or special mode drives active-low one-of-four unit selects.
// RULE_17: Host-compatible mode drives selects 1 and 2 from operations register.
// RULE_18: Host-compatible mode drives selects 3 and 4 as motor enables.
// RULE_19: During reset all drive outputs sit inactive high.
// RULE_20: Software keeps the rate field steady during a disk transfer.
module fdp_drive_port #(
	parameter int unsigned STEP_GAP_CYC = fdp_pkg::STEP_GAP_CYC
) (
	input  wire logic                       i_core_clk,
	input  wire logic                       i_rst,
	input  wire logic [fdp_pkg::AVS_AW-1:0] i_avs_address,
	input  wire logic                       i_avs_read,
	input  wire logic                       i_avs_write,
	input  wire logic [31:0]                i_avs_writedata,
	input  wire logic [3:0]                 i_avs_byteenable,
	output logic      [31:0]                o_avs_readdata,
	output logic                            o_avs_waitrequest,
	input  wire logic                       i_disk_change_gate_n,
	input  wire logic                       i_media_swap_status_n,
	input  wire logic                       i_raw_read_stream,
	input  wire logic                       i_alt_rate_clock,
	input  wire logic                       i_two_speed_spindle_n,
	input  wire logic                       i_precomp_amount_sel,
	output logic                            o_side_select,
	output logic                            o_write_gate_n,
	output logic                            o_write_flux_stream,
	output logic                            o_step_direction,
	output logic                            o_step_n,
	output logic                            o_unit_select_1_n,
	output logic                            o_unit_select_2_n,
	output logic                            o_unit_select_3_n,
	output logic                            o_unit_select_4_n
);
	import fdp_pkg::*;

	typedef enum logic [1:0] {SQ_IDLE, SQ_STEP, SQ_WLEAD, SQ_WRITE} fdp_seq_e;

	initial begin
		if (STEP_GAP_CYC < 1 || STEP_GAP_CYC > 20'hF_FFFF) begin
			$error("fdp_drive_port: STEP_GAP_CYC out of range");
		end
	end

	// Pin synchronisers: first stage feeds only the second
	logic [5:0] sync1_r, sync2_r;
	logic       rdd_prev_r, alt_prev_r;
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			sync1_r    <= 6'h37; // Alt clock rests low, other pins high
			sync2_r    <= 6'h37;
			rdd_prev_r <= 1'b1;
			alt_prev_r <= 1'b0;
		end else begin
			sync1_r    <= {i_precomp_amount_sel, i_two_speed_spindle_n, i_alt_rate_clock,
			               i_raw_read_stream, i_media_swap_status_n, i_disk_change_gate_n};
			sync2_r    <= sync1_r;
			rdd_prev_r <= sync2_r[2];
			alt_prev_r <= sync2_r[3];
		end
	end
	logic gate_n_s, swap_n_s, rdd_s, alt_s, spindle_n_s, pcsel_s;
	assign {pcsel_s, spindle_n_s, alt_s, rdd_s, swap_n_s, gate_n_s} = sync2_r;

	// Bus decode
	logic wr_ops, wr_ctrl, wr_mode, wr_cmd, wr_flux, be0, be1;
	assign be0     = i_avs_byteenable[0];
	assign be1     = i_avs_byteenable[1];
	assign wr_ops  = i_avs_write && i_avs_address == OFS_OPS && be0;
	assign wr_ctrl = i_avs_write && i_avs_address == OFS_CTRL && be0;
	assign wr_mode = i_avs_write && i_avs_address == OFS_MODE && be0;
	assign wr_cmd  = i_avs_write && i_avs_address == OFS_CMD;
	assign wr_flux = i_avs_write && i_avs_address == OFS_FLUX && be0;

	// Host registers and sequencer state
	logic [7:0]  ops_r,  ops_nxt;
	logic [1:0]  ctrl_r, ctrl_nxt;
	logic [1:0]  mode_r, mode_nxt;
	logic [15:0] cmd_r,  cmd_nxt;
	fdp_seq_e    seq_r,  seq_nxt;
	logic [4:0]  lead_r, lead_nxt;
	logic [7:0]  rdcnt_r, rdcnt_nxt;
	logic        rd_done_r, rd_done_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic        flux_busy, flux_take, step_start;

	fdp_step_if step_bus ();

	// Flux byte waits while the shifter holds a byte
	assign o_avs_waitrequest = (i_avs_read && !rd_done_r) || (wr_flux && flux_busy);
	assign flux_take = wr_flux && !flux_busy && seq_r == SQ_WRITE;
	assign step_start = seq_r == SQ_IDLE && wr_cmd && be0 && i_avs_writedata[CMD_STEP];

	logic alt_used;

	// Read mux for a register offset
	function automatic logic [31:0] fdp_rd(input logic [4:0] a);
		logic [31:0] d;
		d = 32'h0000_0000;
		if (a == OFS_OPS) begin
			d[7:0] = ops_r;
		end else if (a == OFS_CTRL) begin
			d[1:0] = ctrl_r;
			d[CTRL_SWAP] = !gate_n_s && swap_n_s; // [RULE_01]
		end else if (a == OFS_MODE) begin
			d[1:0] = mode_r;
		end else if (a == OFS_CMD) begin
			d[15:0] = cmd_r;
		end else if (a == OFS_STAT) begin
			d[ST_STEP]  = step_bus.busy;
			d[ST_WGATE] = !o_write_gate_n;
			d[ST_ALT]   = alt_used;
			d[ST_FLUX]  = flux_busy;
			d[ST_RDCNT +: 8] = rdcnt_r;
		end
		return d;
	endfunction : fdp_rd

	// Next values of registers, sequencer and bus answer
	always_comb begin
		ops_nxt     = ops_r;
		ctrl_nxt    = ctrl_r;
		mode_nxt    = mode_r;
		cmd_nxt     = cmd_r;
		seq_nxt     = seq_r;
		lead_nxt    = lead_r;
		rdcnt_nxt   = rdcnt_r;
		rd_done_nxt = i_avs_read && !rd_done_r;
		rdata_nxt   = rdata_r;
		if (i_avs_read && !rd_done_r) begin
			rdata_nxt = fdp_rd(i_avs_address);
		end
		if (wr_ops) begin
			ops_nxt = i_avs_writedata[7:0]; // [RULE_02]
		end
		if (wr_ctrl) begin
			ctrl_nxt = i_avs_writedata[1:0]; // [RULE_03]
		end
		if (wr_mode) begin
			mode_nxt = i_avs_writedata[1:0];
		end
		if (wr_cmd && be0) begin
			cmd_nxt[7:0] = i_avs_writedata[7:0];
			cmd_nxt[CMD_STEP] = 1'b0;
		end
		if (wr_cmd && be1) begin
			cmd_nxt[15:8] = i_avs_writedata[15:8];
		end
		if (rdd_prev_r && !rdd_s) begin
			rdcnt_nxt = rdcnt_r + 8'h01; // [RULE_06]
		end
		unique case (seq_r)
			SQ_IDLE: begin
				if (step_start) begin
					seq_nxt = SQ_STEP;
				end else if (cmd_r[CMD_WRITE]) begin
					seq_nxt  = SQ_WLEAD;
					lead_nxt = 5'(WG_LEAD_CYC - 1);
				end
			end
			SQ_STEP: begin
				if (!step_bus.busy) begin
					seq_nxt = SQ_IDLE;
				end
			end
			SQ_WLEAD: begin
				// Gate settles low ahead of the first flux pulse [RULE_12]
				if (lead_r == 5'h00) begin
					seq_nxt = SQ_WRITE;
				end else begin
					lead_nxt = lead_r - 5'h01;
				end
			end
			SQ_WRITE: begin
				if (!cmd_r[CMD_WRITE] && !flux_busy) begin
					seq_nxt = SQ_IDLE;
				end
			end
		endcase
	end

	// Register update; reset gives base mode and idle sequencer [RULE_04] [RULE_05]
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			ops_r     <= OPS_RST;
			ctrl_r    <= CTRL_RST;
			mode_r    <= MODE_RST;
			cmd_r     <= 16'h0000;
			seq_r     <= SQ_IDLE;
			lead_r    <= 5'h00;
			rdcnt_r   <= 8'h00;
			rd_done_r <= 1'b0;
			rdata_r   <= 32'h0000_0000;
		end else begin
			ops_r     <= ops_nxt;
			ctrl_r    <= ctrl_nxt;
			mode_r    <= mode_nxt;
			cmd_r     <= cmd_nxt;
			seq_r     <= seq_nxt;
			lead_r    <= lead_nxt;
			rdcnt_r   <= rdcnt_nxt;
			rd_done_r <= rd_done_nxt;
			rdata_r   <= rdata_nxt;
		end
	end
	assign o_avs_readdata = rdata_r;

	// Alternate clock only on request and never with a two-speed drive [RULE_07] [RULE_08]
	assign alt_used = ctrl_r == RATE_300 && spindle_n_s;

	// Bit cell tick: main clock divider or alternate clock edges [RULE_09]
	logic [7:0] cell_r, cell_nxt;
	logic       tick;
	always_comb begin
		cell_nxt = cell_r;
		tick     = 1'b0;
		if (alt_used) begin
			if (alt_s && !alt_prev_r) begin
				cell_nxt = cell_r + 8'h01;
				if (cell_r >= 8'(ALT_EDGES - 1)) begin
					cell_nxt = 8'h00;
					tick     = 1'b1;
				end
			end
		end else begin
			cell_nxt = cell_r + 8'h01;
			if (cell_r >= (ctrl_r == RATE_250 ? 8'(CELL_250_CYC - 1) :
			               ctrl_r == RATE_125 ? 8'(CELL_125_CYC - 1) : 8'(CELL_500_CYC - 1))) begin
				cell_nxt = 8'h00;
				tick     = 1'b1;
			end
		end
	end

	// Flux shifter: MSB first, a one bit makes a delayed low pulse
	logic [7:0] sh_r, sh_nxt;
	logic [3:0] nbit_r, nbit_nxt;
	logic [2:0] dly_r, dly_nxt;
	logic [2:0] pw_r, pw_nxt;
	logic       pend_r, pend_nxt;
	logic [2:0] pc_cyc;
	assign flux_busy = nbit_r != 4'h0 || pend_r || pw_r != 3'h0;
	// Inner tracks shift the pulse by the pin-chosen amount [RULE_10]
	assign pc_cyc = !cmd_r[CMD_INNER] ? 3'h0 : pcsel_s ? 3'(PC_SHORT_CYC) : 3'(PC_LONG_CYC);
	always_comb begin
		sh_nxt   = sh_r;
		nbit_nxt = nbit_r;
		dly_nxt  = dly_r;
		pw_nxt   = pw_r;
		pend_nxt = pend_r;
		if (pw_r != 3'h0) begin
			pw_nxt = pw_r - 3'h1;
		end else if (pend_r) begin
			if (dly_r == 3'h0) begin
				pend_nxt = 1'b0;
				pw_nxt   = 3'(WD_PULSE_CYC);
			end else begin
				dly_nxt = dly_r - 3'h1;
			end
		end
		// A one bit at a tick wins over the clear of the pending pulse
		if (flux_take) begin
			sh_nxt   = i_avs_writedata[7:0];
			nbit_nxt = 4'h8;
		end else if (tick && nbit_r != 4'h0) begin
			sh_nxt   = {sh_r[6:0], 1'b0};
			nbit_nxt = nbit_r - 4'h1;
			if (sh_r[7]) begin
				pend_nxt = 1'b1;
				dly_nxt  = pc_cyc;
			end
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			cell_r <= 8'h00;
			sh_r   <= 8'h00;
			nbit_r <= 4'h0;
			dly_r  <= 3'h0;
			pw_r   <= 3'h0;
			pend_r <= 1'b0;
		end else begin
			cell_r <= cell_nxt;
			sh_r   <= sh_nxt;
			nbit_r <= nbit_nxt;
			dly_r  <= dly_nxt;
			pw_r   <= pw_nxt;
			pend_r <= pend_nxt;
		end
	end

	// Step pulse generator
	assign step_bus.start = step_start;
	assign step_bus.count = i_avs_writedata[15:8];
	fdp_step_gen #(
		.PULSE_CYC (STEP_PULSE_CYC),
		.GAP_CYC   (STEP_GAP_CYC)
	) u_step (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.step       (step_bus.gen)
	);

	// Registered drive outputs, all inactive high under reset [RULE_19]
	logic [3:0] sel_n;
	always_comb begin
		if (mode_r == MODE_COMPAT) begin
			sel_n = ~{ops_r[OPS_MO2], ops_r[OPS_MO1], ops_r[OPS_DS2], ops_r[OPS_DS1]}; // [RULE_17] [RULE_18]
		end else begin
			sel_n = ~(4'h1 << cmd_r[CMD_UNIT +: 2]); // [RULE_16]
		end
	end
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_side_select       <= 1'b1;
			o_write_gate_n      <= 1'b1;
			o_write_flux_stream <= 1'b1;
			o_step_direction    <= 1'b1;
			o_step_n            <= 1'b1;
			{o_unit_select_4_n, o_unit_select_3_n, o_unit_select_2_n, o_unit_select_1_n} <= 4'hF;
		end else begin
			o_side_select       <= !cmd_r[CMD_SIDE]; // [RULE_11]
			o_write_gate_n      <= !(seq_r == SQ_WLEAD || seq_r == SQ_WRITE); // [RULE_12]
			o_write_flux_stream <= pw_r == 3'h0; // [RULE_13]
			o_step_direction    <= cmd_r[CMD_OUT]; // [RULE_14]
			o_step_n            <= step_bus.step_n; // [RULE_15]
			{o_unit_select_4_n, o_unit_select_3_n, o_unit_select_2_n, o_unit_select_1_n} <= sel_n;
		end
	end

	AST_CHANGE_ON_BIT7: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_01]
		(i_avs_read && !rd_done_r && i_avs_address == OFS_CTRL) |=>
		(o_avs_readdata[CTRL_SWAP] == ($past(swap_n_s) && !$past(gate_n_s)) && !o_avs_waitrequest))
		else $error("disk change bit wrong on control read");
	AST_OPS_LATCH: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_02]
		wr_ops |=> ops_r == $past(i_avs_writedata[7:0]))
		else $error("operations register not latched");
	AST_CTRL_LATCH: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_03]
		wr_ctrl |=> ctrl_r == $past(i_avs_writedata[1:0]) ##1 (i_avs_write || $stable(ctrl_r)))
		else $error("control register not latched");
	AST_RESET_BASE: assert property (@(posedge i_core_clk) // [RULE_05]
		$fell(i_rst) |-> mode_r == MODE_BASE && seq_r == SQ_IDLE && o_write_gate_n && o_step_n)
		else $error("reset did not return to base and idle");
	AST_NO_ALT_TWO_SPEED: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_08]
		!spindle_n_s || ctrl_r != RATE_300 |-> !alt_used)
		else $error("alternate clock used when forbidden");
	AST_GATE_COVERS_FLUX: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_12]
		$fell(o_write_flux_stream) |-> !o_write_gate_n && $past(!o_write_gate_n, 2))
		else $error("flux pulse outside write gate");
	AST_PULSE_WIDTH: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_13]
		$fell(o_write_flux_stream) |-> !o_write_flux_stream[*7] ##1 o_write_flux_stream)
		else $error("write pulse width wrong");
	AST_SIDE_LEVEL: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_11]
		##1 o_side_select == !$past(cmd_r[CMD_SIDE]))
		else $error("side select polarity wrong");
	AST_COMPAT_SEL: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_17] [RULE_18]
		mode_r == MODE_COMPAT |=> o_unit_select_1_n == !$past(ops_r[OPS_DS1])
		&& o_unit_select_2_n == !$past(ops_r[OPS_DS2])
		&& o_unit_select_3_n == !$past(ops_r[OPS_MO1])
		&& o_unit_select_4_n == !$past(ops_r[OPS_MO2]))
		else $error("compat selects do not follow operations register");
	AST_BASE_ONEHOT: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_16]
		mode_r != MODE_COMPAT && $stable(mode_r) |=> $countones({o_unit_select_4_n,
		o_unit_select_3_n, o_unit_select_2_n, o_unit_select_1_n}) == 3)
		else $error("unit selects not one of four");
	AST_PRECOMP_DELAY: assert property (@(posedge i_core_clk) disable iff (i_rst) // [RULE_10]
		(tick && nbit_r != 4'h0 && !flux_take && sh_r[7] && cmd_r[CMD_INNER]) |->
		if (pcsel_s) ##7 $fell(o_write_flux_stream) else ##8 $fell(o_write_flux_stream))
		else $error("inner track precompensation delay wrong");
endmodule : fdp_drive_port

/* testbench/fdp_drive_model.sv */
// Purpose: Behavioural drive that counts step and write pulses and makes read flux
// Assumes: Pins are level signals with no clock of their own
// Notes:   Counters only grow; the bench works on differences
module fdp_drive_model (
	input  wire logic i_step_n,
	input  wire logic i_write_flux_stream,
	input  wire logic i_write_gate_n,
	output logic      o_raw_read_stream,
	output logic      o_media_swap_status_n
);
	timeunit 1ns;
	timeprecision 100ps;
	int steps = 0;
	int fluxes = 0;
	int bad_flux = 0;

	// Idle lines rest high
	initial begin
		o_raw_read_stream = 1'b1;
		o_media_swap_status_n = 1'b1;
	end

	// One track moved per low step pulse
	always @(negedge i_step_n) steps++;

	// Every flux written counts; one seen while the write gate is not open also counts as bad
	always @(negedge i_write_flux_stream) begin
		fluxes++;
		if (i_write_gate_n !== 1'b0) bad_flux++;
	end

	// Emits n read flux transitions, each low long enough to pass the pin sync
	task automatic make_flux(input int n);
		#10;
		repeat (n) begin
			#120 o_raw_read_stream = 1'b0;
			#120 o_raw_read_stream = 1'b1;
		end
	endtask : make_flux
endmodule : fdp_drive_model

/* testbench/testbench.sv */
// Purpose: Self-checking bench for the drive port logic
// Assumes: Step gap shortened to 10 cycles
// Notes:   Register readback first, then select table, reset, rate, step, write and read flux cases
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import fdp_pkg::*;
	typedef struct packed {logic [1:0] mode; logic [7:0] ops; logic [7:0] cmd; logic [5:0] exp;} fdp_row_s;
	logic clk = 0, rst = 1, rd = 0, wr = 0, gate_n = 0, spin_n = 1, pc_sel = 0, altclk = 0;
	logic [4:0] adr = '0;
	logic [31:0] wdat = '0, rdat, q, q0;
	logic wreq, side, wg_n, wf, dir, step_n, s1, s2, s3, s4, raw, swap_n;
	int n_errors = 0, n_tests = 0, cyc = 0, b;
	fdp_row_s rows[6] = '{{MODE_BASE, 8'h00, 8'h00, 6'b10_1110}, {MODE_BASE, 8'h00, 8'h27, 6'b01_0111},
		{MODE_SPECIAL, 8'h00, 8'h01, 6'b10_1101}, {MODE_SPECIAL, 8'h00, 8'h06, 6'b00_1011},
		{MODE_COMPAT, 8'h11, 8'h00, 6'b10_1010}, {MODE_COMPAT, 8'h22, 8'h00, 6'b10_0101}};
	wire [8:0] pins = {side, wg_n, wf, dir, step_n, s4, s3, s2, s1};

	fdp_drive_port #(.STEP_GAP_CYC(10)) dut (.i_core_clk(clk), .i_rst(rst), .i_avs_address(adr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(4'hF),
		.o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .i_disk_change_gate_n(gate_n),
		.i_media_swap_status_n(swap_n), .i_raw_read_stream(raw), .i_alt_rate_clock(altclk),
		.i_two_speed_spindle_n(spin_n), .i_precomp_amount_sel(pc_sel), .o_side_select(side),
		.o_write_gate_n(wg_n), .o_write_flux_stream(wf), .o_step_direction(dir), .o_step_n(step_n),
		.o_unit_select_1_n(s1), .o_unit_select_2_n(s2), .o_unit_select_3_n(s3), .o_unit_select_4_n(s4));
	fdp_drive_model drv (.i_step_n(step_n), .i_write_flux_stream(wf), .i_write_gate_n(wg_n),
		.o_raw_read_stream(raw), .o_media_swap_status_n(swap_n));

	// Core and alternate clocks
	initial forever #20 clk = ~clk;
	initial forever #52 altclk = ~altclk;

	// Cuts a hang short
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			summarize();
		end
	end

	// One bus cycle, held until waitrequest is seen low at a falling edge
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		logic wt;
		@(posedge clk);
		rd <= !w;
		wr <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(negedge clk);
			wt = wreq;
			q = rdat;
			@(posedge clk);
		end while (wt !== 1'b0);
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus

	task automatic summarize();
		$display("tests=%0d errors=%0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : summarize

	// Main sequence
	initial begin
		@(negedge clk);
		`CHK(pins, 9'h1FF)
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		bus(1, OFS_OPS, 32'h0000_00A5);
		bus(0, OFS_OPS, 0);
		`CHK(q, 32'h0000_00A5)
		bus(1, OFS_CTRL, 32'h0000_00FF);
		bus(0, OFS_CTRL, 0);
		`CHK(q, 32'h0000_0083)
		bus(0, 5'h18, 0);
		`CHK(q, 32'h0000_0000)
		foreach (rows[i]) begin
			bus(1, OFS_MODE, {30'h0, rows[i].mode});
			bus(1, OFS_OPS, {24'h0, rows[i].ops});
			bus(1, OFS_CMD, {24'h0, rows[i].cmd});
			repeat (3) @(posedge clk);
			`CHK({side, dir, s4, s3, s2, s1}, rows[i].exp)
		end
		$display("select table done");
		rst <= 1'b1;
		@(negedge clk);
		`CHK(pins, 9'h1FF)
		@(posedge clk);
		rst <= 1'b0;
		bus(0, OFS_MODE, 0);
		`CHK(q[1:0], MODE_BASE)
		bus(1, OFS_OPS, 32'h0000_0011);
		bus(1, OFS_CMD, 32'h0000_0002);
		repeat (3) @(posedge clk);
		`CHK({s4, s3, s2, s1}, 4'b1011)
		$display("reset test done");
		for (int r = 0; r < 4; r++) begin
			for (int s = 0; s < 2; s++) begin
				spin_n <= s[0];
				bus(1, OFS_CTRL, r);
				repeat (5) @(posedge clk);
				bus(0, OFS_STAT, 0);
				`CHK(q[ST_ALT], (r == 1 && s == 1))
			end
		end
		gate_n <= 1'b1;
		bus(1, OFS_CTRL, 0);
		repeat (3) @(posedge clk);
		bus(0, OFS_CTRL, 0);
		`CHK(q[7], 1'b0)
		$display("rate test done");
		b = drv.steps;
		bus(1, OFS_CMD, 32'h0000_0330);
		repeat (400) @(posedge clk);
		`CHK(drv.steps - b, 3)
		`CHK(dir, 1'b1)
		bus(1, OFS_CMD, 32'h0000_0010);
		repeat (50) @(posedge clk);
		`CHK(drv.steps - b, 3)
		$display("step test done");
		b = drv.fluxes;
		pc_sel <= 1'b1;
		bus(1, OFS_CMD, 32'h0000_0048); // Inner track write, rate left untouched
		repeat (30) @(posedge clk);
		`CHK(wg_n, 1'b0)
		bus(1, OFS_FLUX, 32'h0000_0081);
		bus(1, OFS_FLUX, 32'h0000_0040);
		pc_sel <= 1'b0;
		repeat (500) @(posedge clk);
		bus(1, OFS_CMD, 0);
		repeat (50) @(posedge clk);
		`CHK(drv.fluxes - b, 3)
		`CHK(drv.bad_flux, 0)
		`CHK(wg_n, 1'b1)
		$display("write test done");
		bus(0, OFS_STAT, 0);
		q0 = q;
		drv.make_flux(5);
		repeat (5) @(posedge clk);
		bus(0, OFS_STAT, 0);
		`CHK(8'(q[15:8] - q0[15:8]), 8'h05)
		$display("read flux test done");
		summarize();
	end
endmodule : testbench
